// ==== verilog/mfsg_pkg.sv ====
// Shared constants and types for the media and x87 state and fault gate.
package mfsg_pkg;
    localparam int VEC_REG_WIDTH = 128;
    localparam int FP_REG_WIDTH = 80;
    localparam int PACKED_WIDTH = 64;
    localparam int FP_WORD_WIDTH = 16;
    localparam int OPC_WIDTH = 11;
    localparam int PTR_WIDTH = 64;
    localparam int VCS_WIDTH = 32;
    localparam int ADDR_WIDTH = 4;
    // Register offsets on the software port.
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_FAULT_STATUS = 4'h1;
    localparam logic [3:0] OFS_FAULT_MASK = 4'h2;
    localparam logic [3:0] OFS_FP_CONTROL = 4'h3;
    localparam logic [3:0] OFS_FP_STATUS = 4'h4;
    localparam logic [3:0] OFS_FP_TAG = 4'h5;
    localparam logic [3:0] OFS_LAST_OPCODE = 4'h6;
    localparam logic [3:0] OFS_LAST_IP_LO = 4'h7;
    localparam logic [3:0] OFS_LAST_IP_HI = 4'h8;
    localparam logic [3:0] OFS_LAST_DP_LO = 4'h9;
    localparam logic [3:0] OFS_LAST_DP_HI = 4'hA;
    localparam logic [3:0] OFS_VEC_CS = 4'hB;
    // Control register bit positions.
    localparam int CTRL_SAVE_OK = 0;
    localparam int CTRL_HANDLER_OK = 1;
    localparam int CTRL_SIMULATE = 2;
    localparam int CTRL_MONITOR = 3;
    localparam int CTRL_TASK_SW = 4;
    localparam int CTRL_LONG_MODE = 5;
    localparam int CTRL_BITS = 6;
    // Fault status bit positions.
    localparam int FLT_INVALID = 0;
    localparam int FLT_UNAVAIL = 1;
    localparam int FLT_VECTOR_FP = 2;
    localparam int FLT_PENDING_FP = 3;
    localparam int FLT_BITS = 4;
    // Status word fields.
    localparam int FSW_ERR_SUMMARY = 7;
    localparam int FSW_TOP_LO = 11;
    localparam int FSW_TOP_HI = 13;
    // Reset values and the legacy vector register count.
    localparam logic [15:0] FCW_RESET = 16'h037F;
    localparam logic [15:0] FTW_RESET = 16'hFFFF;
    localparam logic [31:0] VCS_RESET = 32'h00001F80;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam int LEGACY_VEC_REGS = 8;
    typedef enum logic [2:0]
    {
        MFSG_CLS_NONE,
        MFSG_CLS_WIDE_VEC,
        MFSG_CLS_PACKED,
        MFSG_CLS_FP,
        MFSG_CLS_FP_CTRL,
        MFSG_CLS_WAIT
    } mfsg_class_e;
    typedef enum logic [2:0]
    {
        MFSG_RES_EXEC,
        MFSG_RES_INVALID,
        MFSG_RES_UNAVAIL,
        MFSG_RES_VECTOR_FP,
        MFSG_RES_PENDING_FP
    } mfsg_result_e;
endpackage : mfsg_pkg

// ==== verilog/mfsg_gate.sv ====
// Fault gate and architectural state for vector, packed-integer and x87 instructions.
`timescale 1ns/1ps
module mfsg_gate
#(
    parameter int PTR_W = mfsg_pkg::PTR_WIDTH
)
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset,
    // Software register port.
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Instruction issue.
    input wire logic issue_valid,
    input wire mfsg_pkg::mfsg_class_e issue_class,
    input wire logic [7:0] issue_opc_first,
    input wire logic [7:0] issue_opc_second,
    input wire logic [PTR_W-1:0] issue_ip,
    input wire logic [1:0] issue_ptr_size,
    input wire logic issue_mem,
    input wire logic [PTR_W-1:0] issue_data_addr,
    input wire logic issue_vec_exc,
    input wire logic issue_vec_exc_masked,
    input wire logic issue_fp_unmasked_exc,
    // Register file access for execution.
    input wire logic vec_wr,
    input wire logic [3:0] vec_idx,
    input wire logic [127:0] vec_wdata,
    output logic [127:0] vec_rdata,
    input wire logic fp_wr,
    input wire logic fp_packed,
    input wire logic [2:0] fp_idx,
    input wire logic [79:0] fp_wdata,
    output logic [79:0] fp_rdata,
    // Issue outcome.
    output mfsg_pkg::mfsg_result_e result,
    output logic result_valid,
    output logic irq
);
    logic [5:0] ctrl_ff;
    logic [3:0] flt_status_ff;
    logic [3:0] flt_mask_ff;
    logic [15:0] fcw_ff;
    logic [15:0] fsw_ff;
    logic [15:0] ftw_ff;
    logic [10:0] last_fp_opcode_latch_ff;
    logic [PTR_W-1:0] last_ip_ff;
    logic [PTR_W-1:0] last_dp_ff;
    logic [31:0] vcs_ff;
    logic [127:0] vec_mem [16];
    logic [79:0] fp_mem [8];
    logic [31:0] nxt_rdata;
    mfsg_pkg::mfsg_result_e nxt_result;
    logic [3:0] flt_set;

    if (PTR_W < 32 || PTR_W > 64)
    begin : g_ptr_check
        $error("PTR_W must lie between 32 and 64.");
    end

    function automatic logic [PTR_W-1:0] size_ptr(input logic [PTR_W-1:0] p,
                                                    input logic [1:0] sz);
        logic [PTR_W-1:0] m;
        m = '1;
        if (sz == 2'h0)
            m = PTR_W'({32{1'b1}});
        else if (sz == 2'h1)
            m = PTR_W'({48{1'b1}});
        return p & m;
    endfunction : size_ptr

    wire logic save_ok = ctrl_ff[mfsg_pkg::CTRL_SAVE_OK];
    wire logic handler_ok = ctrl_ff[mfsg_pkg::CTRL_HANDLER_OK];
    wire logic simulate = ctrl_ff[mfsg_pkg::CTRL_SIMULATE];
    wire logic monitor = ctrl_ff[mfsg_pkg::CTRL_MONITOR];
    wire logic task_sw = ctrl_ff[mfsg_pkg::CTRL_TASK_SW];
    wire logic long_mode = ctrl_ff[mfsg_pkg::CTRL_LONG_MODE];
    wire logic is_vec = issue_class == mfsg_pkg::MFSG_CLS_WIDE_VEC;
    wire logic is_packed = issue_class == mfsg_pkg::MFSG_CLS_PACKED;
    wire logic is_fp = issue_class == mfsg_pkg::MFSG_CLS_FP;
    wire logic is_fp_ctrl = issue_class == mfsg_pkg::MFSG_CLS_FP_CTRL;
    wire logic is_any = is_vec | is_packed | is_fp | is_fp_ctrl
                        | (issue_class == mfsg_pkg::MFSG_CLS_WAIT);
    wire logic err_summary = fsw_ff[mfsg_pkg::FSW_ERR_SUMMARY];
    wire logic lazy_trap = !simulate && monitor && task_sw;
    wire logic vec_blocked = is_vec && (!save_ok || simulate);
    wire logic vec_idx_ok = long_mode || (vec_idx < 4'(mfsg_pkg::LEGACY_VEC_REGS));
    wire logic executes = issue_valid && nxt_result == mfsg_pkg::MFSG_RES_EXEC;
    wire logic fp_record = executes && is_fp;
    wire logic [2:0] top = fsw_ff[mfsg_pkg::FSW_TOP_HI:mfsg_pkg::FSW_TOP_LO];
    wire logic wr_hit_status = reg_wr && reg_addr == mfsg_pkg::OFS_FAULT_STATUS;
    wire logic [63:0] last_ip_wide = 64'(last_ip_ff);
    wire logic [63:0] last_dp_wide = 64'(last_dp_ff);

    always_comb
    begin
        nxt_result = mfsg_pkg::MFSG_RES_EXEC;
        if (is_any && lazy_trap)
            nxt_result = mfsg_pkg::MFSG_RES_UNAVAIL;
        else if (vec_blocked)
            nxt_result = mfsg_pkg::MFSG_RES_INVALID;
        else if (is_vec && issue_vec_exc && !issue_vec_exc_masked)
            nxt_result = handler_ok ? mfsg_pkg::MFSG_RES_VECTOR_FP
                                    : mfsg_pkg::MFSG_RES_INVALID;
        else if (is_packed && err_summary)
            nxt_result = mfsg_pkg::MFSG_RES_PENDING_FP;
    end

    assign flt_set[mfsg_pkg::FLT_INVALID] = issue_valid
        && nxt_result == mfsg_pkg::MFSG_RES_INVALID;
    assign flt_set[mfsg_pkg::FLT_UNAVAIL] = issue_valid
        && nxt_result == mfsg_pkg::MFSG_RES_UNAVAIL;
    assign flt_set[mfsg_pkg::FLT_VECTOR_FP] = issue_valid
        && nxt_result == mfsg_pkg::MFSG_RES_VECTOR_FP;
    assign flt_set[mfsg_pkg::FLT_PENDING_FP] = issue_valid
        && nxt_result == mfsg_pkg::MFSG_RES_PENDING_FP;
    assign irq = |(flt_status_ff & flt_mask_ff);
    assign vec_rdata = vec_mem[vec_idx_ok ? vec_idx : 4'h0];
    assign fp_rdata = fp_packed ? {16'h0000, fp_mem[fp_idx][63:0]} : fp_mem[fp_idx];

    always_comb
    begin
        nxt_rdata = 32'h00000000;
        unique case (reg_addr)
            mfsg_pkg::OFS_CTRL: nxt_rdata = {26'h0, ctrl_ff};
            mfsg_pkg::OFS_FAULT_STATUS: nxt_rdata = {28'h0, flt_status_ff};
            mfsg_pkg::OFS_FAULT_MASK: nxt_rdata = {28'h0, flt_mask_ff};
            mfsg_pkg::OFS_FP_CONTROL: nxt_rdata = {16'h0, fcw_ff};
            mfsg_pkg::OFS_FP_STATUS: nxt_rdata = {16'h0, fsw_ff};
            mfsg_pkg::OFS_FP_TAG: nxt_rdata = {16'h0, ftw_ff};
            mfsg_pkg::OFS_LAST_OPCODE: nxt_rdata = {21'h0, last_fp_opcode_latch_ff};
            mfsg_pkg::OFS_LAST_IP_LO: nxt_rdata = last_ip_ff[31:0];
            mfsg_pkg::OFS_LAST_IP_HI: nxt_rdata = last_ip_wide[63:32];
            mfsg_pkg::OFS_LAST_DP_LO: nxt_rdata = last_dp_ff[31:0];
            mfsg_pkg::OFS_LAST_DP_HI: nxt_rdata = last_dp_wide[63:32];
            mfsg_pkg::OFS_VEC_CS: nxt_rdata = vcs_ff;
            default: nxt_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            reg_rdata <= 32'h00000000;
        else
            reg_rdata <= reg_rd ? nxt_rdata : 32'h00000000;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            result <= mfsg_pkg::MFSG_RES_EXEC;
            result_valid <= 1'b0;
        end
        else
        begin
            result <= nxt_result;
            result_valid <= issue_valid && is_any;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            ctrl_ff <= mfsg_pkg::CTRL_RESET;
            flt_mask_ff <= 4'h0;
            vcs_ff <= mfsg_pkg::VCS_RESET;
            fcw_ff <= mfsg_pkg::FCW_RESET;
        end
        else if (reg_wr)
        begin
            if (reg_addr == mfsg_pkg::OFS_CTRL)
                ctrl_ff <= reg_wdata[5:0];
            if (reg_addr == mfsg_pkg::OFS_FAULT_MASK)
                flt_mask_ff <= reg_wdata[3:0];
            if (reg_addr == mfsg_pkg::OFS_VEC_CS)
                vcs_ff <= reg_wdata;
            if (reg_addr == mfsg_pkg::OFS_FP_CONTROL)
                fcw_ff <= reg_wdata[15:0];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            flt_status_ff <= 4'h0;
        else
            flt_status_ff <= (flt_status_ff & ~(wr_hit_status ? reg_wdata[3:0] : 4'h0))
                             | flt_set;
    end

    // Status word: software writes it; packed execution resets the stack head only.
    always_ff @(posedge mclk)
    begin
        if (reset)
            fsw_ff <= 16'h0000;
        else if (reg_wr && reg_addr == mfsg_pkg::OFS_FP_STATUS)
            fsw_ff <= reg_wdata[15:0];
        else if (executes && is_packed)
            fsw_ff[mfsg_pkg::FSW_TOP_HI:mfsg_pkg::FSW_TOP_LO] <= 3'h0;
        else if (executes && is_fp && issue_fp_unmasked_exc)
            fsw_ff[mfsg_pkg::FSW_ERR_SUMMARY] <= 1'b1;
    end

    // Tag word: packed execution marks all valid; x87 writes mark the slot valid.
    always_ff @(posedge mclk)
    begin
        if (reset)
            ftw_ff <= mfsg_pkg::FTW_RESET;
        else if (executes && is_packed)
            ftw_ff <= 16'h0000;
        else if (fp_wr && !fp_packed)
            ftw_ff[{fp_idx - top, 1'b0} +: 2] <= 2'h0;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            last_fp_opcode_latch_ff <= 11'h000;
            last_ip_ff <= '0;
            last_dp_ff <= '0;
        end
        else if (fp_record)
        begin
            last_fp_opcode_latch_ff <= {issue_opc_first[2:0], issue_opc_second};
            last_ip_ff <= size_ptr(issue_ip, issue_ptr_size);
            if (issue_mem)
                last_dp_ff <= size_ptr(issue_data_addr, issue_ptr_size);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (vec_wr && vec_idx_ok)
            vec_mem[vec_idx] <= vec_wdata;
    end

    // Packed writes land in the low 64 bits; the exponent field becomes all ones.
    always_ff @(posedge mclk)
    begin
        if (fp_wr)
            fp_mem[fp_idx] <= fp_packed ? {16'hFFFF, fp_wdata[63:0]} : fp_wdata;
    end

    a_vec_save_gate: assert property (@(posedge mclk) disable iff (reset)
        issue_valid && is_vec && !save_ok && !lazy_trap
        |=> result == mfsg_pkg::MFSG_RES_INVALID && result_valid)
        else $error("Vector run without save enable.");
    a_vec_simulate: assert property (@(posedge mclk) disable iff (reset)
        issue_valid && is_vec && simulate |=> result == mfsg_pkg::MFSG_RES_INVALID)
        else $error("Vector run with simulate flag.");
    a_lazy_trap: assert property (@(posedge mclk) disable iff (reset)
        issue_valid && is_any && lazy_trap |=> result == mfsg_pkg::MFSG_RES_UNAVAIL
        ##0 flt_status_ff[mfsg_pkg::FLT_UNAVAIL])
        else $error("Missing unavailable fault.");
    a_vec_fault_route: assert property (@(posedge mclk) disable iff (reset)
        issue_valid && is_vec && !vec_blocked && !lazy_trap && issue_vec_exc
        && !issue_vec_exc_masked |=> result == (handler_ok ? mfsg_pkg::MFSG_RES_VECTOR_FP
        : mfsg_pkg::MFSG_RES_INVALID))
        else $error("Vector fault routed wrong.");
    a_masked_default: assert property (@(posedge mclk) disable iff (reset)
        issue_valid && is_vec && save_ok && !simulate && !lazy_trap && issue_vec_exc_masked
        |=> result == mfsg_pkg::MFSG_RES_EXEC)
        else $error("Masked vector exception trapped.");
    a_pending_fp: assert property (@(posedge mclk) disable iff (reset)
        issue_valid && is_packed && err_summary && !lazy_trap
        |=> result == mfsg_pkg::MFSG_RES_PENDING_FP)
        else $error("Pending x87 fault missed.");
    a_packed_tag: assert property (@(posedge mclk) disable iff (reset)
        executes && is_packed && !fp_wr && !(reg_wr && reg_addr == mfsg_pkg::OFS_FP_STATUS)
        |=> ftw_ff == 16'h0000 && $stable(fsw_ff[7]))
        else $error("Packed tag update wrong.");
    a_opcode_latch: assert property (@(posedge mclk) disable iff (reset)
        fp_record |=> last_fp_opcode_latch_ff == {$past(issue_opc_first[2:0]),
        $past(issue_opc_second)})
        else $error("Opcode latch wrong.");
    a_ctrl_keeps: assert property (@(posedge mclk) disable iff (reset)
        issue_valid && is_fp_ctrl |=> $stable(last_fp_opcode_latch_ff) && $stable(last_ip_ff))
        else $error("Control instruction changed pointers.");
    a_irq_level: assert property (@(posedge mclk) disable iff (reset)
        (|(flt_set & flt_mask_ff)) && !(reg_wr && reg_addr == mfsg_pkg::OFS_FAULT_MASK)
        |=> irq)
        else $error("Interrupt level wrong.");
    c_lazy: cover property (@(posedge mclk) disable iff (reset) issue_valid && lazy_trap);
    c_vec_fault: cover property (@(posedge mclk) disable iff (reset)
        flt_set[mfsg_pkg::FLT_VECTOR_FP]);
    c_pending: cover property (@(posedge mclk) disable iff (reset)
        flt_set[mfsg_pkg::FLT_PENDING_FP]);
    c_record: cover property (@(posedge mclk) disable iff (reset) fp_record && issue_mem);
endmodule : mfsg_gate

// ==== tb/mfsg_gate_tb_top.sv ====
// Self-checking testbench for the media and x87 state and fault gate.
`timescale 1ns/1ps
module mfsg_gate_tb_top;
    logic mclk;
    logic reset;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic issue_valid;
    mfsg_pkg::mfsg_class_e issue_class;
    logic [7:0] issue_opc_first;
    logic [7:0] issue_opc_second;
    logic [63:0] issue_ip;
    logic [1:0] issue_ptr_size;
    logic issue_mem;
    logic [63:0] issue_data_addr;
    logic issue_vec_exc;
    logic issue_vec_exc_masked;
    logic issue_fp_unmasked_exc;
    logic vec_wr;
    logic [3:0] vec_idx;
    logic [127:0] vec_wdata;
    logic [127:0] vec_rdata;
    logic fp_wr;
    logic fp_packed;
    logic [2:0] fp_idx;
    logic [79:0] fp_wdata;
    logic [79:0] fp_rdata;
    mfsg_pkg::mfsg_result_e result;
    logic result_valid;
    logic irq;
    int err_total = 0;
    int n_compared = 0;
    localparam logic [63:0] IPA = 64'h0000_1234_8765_4320;
    localparam logic [63:0] DPA = 64'h0000_00AB_CDEF_0010;

    mfsg_gate dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .issue_valid(issue_valid),
        .issue_class(issue_class), .issue_opc_first(issue_opc_first),
        .issue_opc_second(issue_opc_second), .issue_ip(issue_ip),
        .issue_ptr_size(issue_ptr_size), .issue_mem(issue_mem),
        .issue_data_addr(issue_data_addr), .issue_vec_exc(issue_vec_exc),
        .issue_vec_exc_masked(issue_vec_exc_masked),
        .issue_fp_unmasked_exc(issue_fp_unmasked_exc), .vec_wr(vec_wr), .vec_idx(vec_idx),
        .vec_wdata(vec_wdata), .vec_rdata(vec_rdata), .fp_wr(fp_wr), .fp_packed(fp_packed),
        .fp_idx(fp_idx), .fp_wdata(fp_wdata), .fp_rdata(fp_rdata), .result(result),
        .result_valid(result_valid), .irq(irq));

    task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(what, {96'h0, exp}, {96'h0, reg_rdata});
    endtask : rdchk

    // Flags are size[1:0], memory, vector exception, vector masked, x87 exception.
    task automatic iss(input mfsg_pkg::mfsg_class_e c, input logic [15:0] opc,
        input logic [5:0] fl, input logic [63:0] ip, input mfsg_pkg::mfsg_result_e exp);
        @(posedge mclk);
        issue_valid <= 1'b1;
        issue_class <= c;
        {issue_opc_first, issue_opc_second} <= opc;
        {issue_ptr_size, issue_mem, issue_vec_exc, issue_vec_exc_masked} <= fl[5:1];
        issue_fp_unmasked_exc <= fl[0];
        issue_ip <= ip;
        issue_data_addr <= DPA;
        @(posedge mclk);
        issue_valid <= 1'b0;
        #1;
        chk("result", {125'h0, exp}, {125'h0, result});
        chk("result_valid", 128'h1, {127'h0, result_valid});
    endtask : iss

    task automatic t_reset();
        rdchk("ctrl", mfsg_pkg::OFS_CTRL, 32'h0);
        rdchk("control word", mfsg_pkg::OFS_FP_CONTROL, 32'h037F);
        rdchk("status word", mfsg_pkg::OFS_FP_STATUS, 32'h0);
        rdchk("tag word", mfsg_pkg::OFS_FP_TAG, 32'hFFFF);
        rdchk("vector csr", mfsg_pkg::OFS_VEC_CS, 32'h00001F80);
        rdchk("unmapped", 4'hF, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_irq();
        iss(mfsg_pkg::MFSG_CLS_WIDE_VEC, 16'h0, 6'h0, IPA, mfsg_pkg::MFSG_RES_INVALID);
        rdchk("fault status", mfsg_pkg::OFS_FAULT_STATUS, 32'h1);
        chk("irq masked", 128'h0, {127'h0, irq});
        wr(mfsg_pkg::OFS_FAULT_MASK, 32'h1);
        chk("irq raised", 128'h1, {127'h0, irq});
        wr(mfsg_pkg::OFS_FAULT_STATUS, 32'h1);
        chk("irq cleared", 128'h0, {127'h0, irq});
        iss(mfsg_pkg::MFSG_CLS_WIDE_VEC, 16'h0, 6'h0, IPA, mfsg_pkg::MFSG_RES_INVALID);
        chk("irq on fault", 128'h1, {127'h0, irq});
        wr(mfsg_pkg::OFS_FAULT_STATUS, 32'h1);
        rdchk("fault cleared", mfsg_pkg::OFS_FAULT_STATUS, 32'h0);
        wr(mfsg_pkg::OFS_FAULT_MASK, 32'h0);
        $display("test irq done");
    endtask : t_irq

    task automatic t_gate();
        mfsg_pkg::mfsg_class_e cl [4];
        cl = '{mfsg_pkg::MFSG_CLS_WIDE_VEC, mfsg_pkg::MFSG_CLS_PACKED,
            mfsg_pkg::MFSG_CLS_FP, mfsg_pkg::MFSG_CLS_WAIT};
        wr(mfsg_pkg::OFS_CTRL, 32'h01);
        iss(mfsg_pkg::MFSG_CLS_WIDE_VEC, 16'h0, 6'h0, IPA, mfsg_pkg::MFSG_RES_EXEC);
        wr(mfsg_pkg::OFS_CTRL, 32'h05);
        iss(mfsg_pkg::MFSG_CLS_WIDE_VEC, 16'h0, 6'h0, IPA, mfsg_pkg::MFSG_RES_INVALID);
        wr(mfsg_pkg::OFS_CTRL, 32'h19);
        foreach (cl[i])
        begin
            iss(cl[i], 16'hD9F8, 6'h0, IPA, mfsg_pkg::MFSG_RES_UNAVAIL);
        end
        rdchk("unavail sticky", mfsg_pkg::OFS_FAULT_STATUS, 32'h3);
        wr(mfsg_pkg::OFS_CTRL, 32'h11);
        iss(mfsg_pkg::MFSG_CLS_FP, 16'hD9F8, 6'h0, IPA, mfsg_pkg::MFSG_RES_EXEC);
        wr(mfsg_pkg::OFS_FAULT_STATUS, 32'hF);
        $display("test gate done");
    endtask : t_gate

    task automatic t_vecexc();
        wr(mfsg_pkg::OFS_CTRL, 32'h01);
        iss(mfsg_pkg::MFSG_CLS_WIDE_VEC, 16'h0, 6'h04, IPA, mfsg_pkg::MFSG_RES_INVALID);
        iss(mfsg_pkg::MFSG_CLS_WIDE_VEC, 16'h0, 6'h06, IPA, mfsg_pkg::MFSG_RES_EXEC);
        wr(mfsg_pkg::OFS_CTRL, 32'h03);
        iss(mfsg_pkg::MFSG_CLS_WIDE_VEC, 16'h0, 6'h04, IPA, mfsg_pkg::MFSG_RES_VECTOR_FP);
        iss(mfsg_pkg::MFSG_CLS_WIDE_VEC, 16'h0, 6'h06, IPA, mfsg_pkg::MFSG_RES_EXEC);
        rdchk("vector fault", mfsg_pkg::OFS_FAULT_STATUS, 32'h5);
        wr(mfsg_pkg::OFS_FAULT_STATUS, 32'hF);
        wr(mfsg_pkg::OFS_CTRL, 32'h0);
        $display("test vector exception done");
    endtask : t_vecexc

    task automatic t_packed();
        wr(mfsg_pkg::OFS_FP_STATUS, 32'h2800);
        iss(mfsg_pkg::MFSG_CLS_PACKED, 16'h0, 6'h01, IPA, mfsg_pkg::MFSG_RES_EXEC);
        rdchk("tag after packed", mfsg_pkg::OFS_FP_TAG, 32'h0);
        rdchk("status after packed", mfsg_pkg::OFS_FP_STATUS, 32'h0);
        iss(mfsg_pkg::MFSG_CLS_FP, 16'hD8C1, 6'h01, IPA, mfsg_pkg::MFSG_RES_EXEC);
        rdchk("error summary", mfsg_pkg::OFS_FP_STATUS, 32'h80);
        iss(mfsg_pkg::MFSG_CLS_PACKED, 16'h0, 6'h0, IPA, mfsg_pkg::MFSG_RES_PENDING_FP);
        rdchk("pending sticky", mfsg_pkg::OFS_FAULT_STATUS, 32'h8);
        wr(mfsg_pkg::OFS_FAULT_STATUS, 32'hF);
        wr(mfsg_pkg::OFS_FP_STATUS, 32'h0);
        rdchk("status written", mfsg_pkg::OFS_FP_STATUS, 32'h0);
        $display("test packed done");
    endtask : t_packed

    task automatic t_x87();
        iss(mfsg_pkg::MFSG_CLS_FP, 16'hD9F8, 6'h28, IPA, mfsg_pkg::MFSG_RES_EXEC);
        rdchk("opcode", mfsg_pkg::OFS_LAST_OPCODE, 32'h1F8);
        rdchk("ip lo", mfsg_pkg::OFS_LAST_IP_LO, IPA[31:0]);
        rdchk("ip hi", mfsg_pkg::OFS_LAST_IP_HI, IPA[63:32]);
        rdchk("dp lo", mfsg_pkg::OFS_LAST_DP_LO, DPA[31:0]);
        rdchk("dp hi", mfsg_pkg::OFS_LAST_DP_HI, DPA[63:32]);
        iss(mfsg_pkg::MFSG_CLS_FP_CTRL, 16'hDBE3, 6'h28, ~IPA, mfsg_pkg::MFSG_RES_EXEC);
        rdchk("opcode kept", mfsg_pkg::OFS_LAST_OPCODE, 32'h1F8);
        rdchk("ip kept", mfsg_pkg::OFS_LAST_IP_LO, IPA[31:0]);
        rdchk("dp kept", mfsg_pkg::OFS_LAST_DP_LO, DPA[31:0]);
        iss(mfsg_pkg::MFSG_CLS_FP, 16'hDC05, 6'h08, IPA, mfsg_pkg::MFSG_RES_EXEC);
        rdchk("opcode two", mfsg_pkg::OFS_LAST_OPCODE, 32'h405);
        rdchk("ip hi narrow", mfsg_pkg::OFS_LAST_IP_HI, 32'h0);
        iss(mfsg_pkg::MFSG_CLS_FP, 16'hD9F8, 6'h18, ~IPA, mfsg_pkg::MFSG_RES_EXEC);
        rdchk("ip hi mid", mfsg_pkg::OFS_LAST_IP_HI, 32'h0000EDCB);
        $display("test x87 pointers done");
    endtask : t_x87

    task automatic t_regs();
        @(posedge mclk);
        vec_wr <= 1'b1;
        vec_idx <= 4'h0;
        vec_wdata <= {4{32'hA5A5_0001}};
        @(posedge mclk);
        vec_idx <= 4'h8;
        vec_wdata <= {4{32'h5A5A_0008}};
        @(posedge mclk);
        vec_wr <= 1'b0;
        #1;
        chk("vec legacy", {4{32'hA5A5_0001}}, vec_rdata);
        wr(mfsg_pkg::OFS_CTRL, 32'h20);
        @(posedge mclk);
        vec_wr <= 1'b1;
        @(posedge mclk);
        vec_wr <= 1'b0;
        #1;
        chk("vec long", {4{32'h5A5A_0008}}, vec_rdata);
        vec_idx <= 4'h0;
        #1;
        chk("vec low kept", {4{32'hA5A5_0001}}, vec_rdata);
        @(posedge mclk);
        fp_wr <= 1'b1;
        fp_idx <= 3'h3;
        fp_packed <= 1'b1;
        fp_wdata <= 80'h0000_1122_3344_5566_7788;
        @(posedge mclk);
        fp_wr <= 1'b0;
        fp_packed <= 1'b0;
        #1;
        chk("alias full", {48'h0, 80'hFFFF_1122_3344_5566_7788}, {48'h0, fp_rdata});
        fp_packed <= 1'b1;
        #1;
        chk("alias packed", {64'h0, 64'h1122_3344_5566_7788}, {48'h0, fp_rdata});
        fp_packed <= 1'b0;
        $display("test register files done");
    endtask : t_regs

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial
    begin
        #(25 * 6000);
        err_total++;
        close_out();
    end

    initial
    begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, issue_valid} = '0;
        issue_class = mfsg_pkg::MFSG_CLS_NONE;
        {issue_opc_first, issue_opc_second, issue_ip, issue_ptr_size, issue_mem} = '0;
        {issue_data_addr, issue_vec_exc, issue_vec_exc_masked, issue_fp_unmasked_exc} = '0;
        {vec_wr, vec_idx, vec_wdata, fp_wr, fp_packed, fp_idx, fp_wdata} = '0;
        reset = 1'b1;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_irq();
        t_gate();
        t_vecexc();
        t_packed();
        t_x87();
        t_regs();
        close_out();
    end
endmodule : mfsg_gate_tb_top
